// ### rtl/video_blit_window_regs.sv
`timescale 1ns/10ps

// Summary of operation
// - 32-byte space, window select at top word
// - Select bits 7-4 pick sub-device
// - Bits 3-0 shift window by 16 bytes
// - Video registers at window base when selected
// - Control: width high bits, source mode
// - Control: destination and source high bits
// - Size: width low bits, height
// - Source holds address or fill colour
// - Destination holds low address bits
// - Destination write starts blit, clones parameters
// - Destination rewrite while busy stalls cycle
// - Video control bit 11 shows page committed
// - Video control bit 10 shows busy
// - Bits 9 and 8 enable syncs
// - Bit 7 sets transfer direction
// - Bit 6 enables pixel fill
module video_blit_window_regs
    import video_blit_pkg::*;
(
    input  wire logic                mclk,
    input  wire logic                sys_rst,
    input  wire logic [ADDR_W-1:0]   io_addr,
    input  wire logic [DATA_W-1:0]   io_data_in,
    output logic      [DATA_W-1:0]   io_data_out,
    output logic                     io_data_oe,
    input  wire logic                io_rd_n,
    input  wire logic                io_wr_n,
    output logic                     io_ready,
    output logic      [3:0]          subdev_sel,
    output logic      [3:0]          window_offset,
    input  wire logic                blit_done,
    input  wire logic                raster_committed,
    output logic                     blit_start,
    output logic                     blit_busy,
    output logic                     blit_linear,
    output logic                     blit_fill,
    output logic                     blit_bottom_up,
    output logic      [WIDTH_W-1:0]  blit_width,
    output logic      [HEIGHT_W-1:0] blit_height,
    output logic      [BADDR_W-1:0]  blit_src_addr,
    output logic      [BADDR_W-1:0]  blit_dst_addr,
    output logic      [DATA_W-1:0]   blit_fill_color,
    output logic                     hsync_en,
    output logic                     vsync_en,
    output logic      [PAGE_W-1:0]   raster_page,
    output logic      [PAGE_W-1:0]   bus_page
);

    // ****************************************************************
    // Pin synchronisers
    // ****************************************************************
    logic [ADDR_W-1:0] addr_meta_reg;
    logic [ADDR_W-1:0] addr_reg;
    logic [DATA_W-1:0] data_meta_reg;
    logic [DATA_W-1:0] data_reg;
    logic [1:0]        rd_meta_reg;
    logic [1:0]        rd_sync_reg;
    logic [1:0]        wr_meta_reg;
    logic [1:0]        wr_sync_reg;
    logic              wr_prev_reg;
    logic              rd_active;
    logic              wr_active;
    logic              wr_fire;

    // Two flops on every pin before any logic looks at it.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            addr_meta_reg <= '0;
            addr_reg      <= '0;
            data_meta_reg <= '0;
            data_reg      <= '0;
            rd_meta_reg   <= 2'h0;
            rd_sync_reg   <= 2'h0;
            wr_meta_reg   <= 2'h0;
            wr_sync_reg   <= 2'h0;
        end else begin
            addr_meta_reg <= io_addr;
            addr_reg      <= addr_meta_reg;
            data_meta_reg <= io_data_in;
            data_reg      <= data_meta_reg;
            rd_meta_reg   <= {1'b0, ~io_rd_n};
            rd_sync_reg   <= rd_meta_reg;
            wr_meta_reg   <= {1'b0, ~io_wr_n};
            wr_sync_reg   <= wr_meta_reg;
        end
    end

    assign rd_active = rd_sync_reg[0];
    assign wr_active = wr_sync_reg[0];

    // Remembers the write strobe level to find its leading edge.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            wr_prev_reg <= 1'b0;
        end else begin
            wr_prev_reg <= wr_active;
        end
    end

    // Each host write cycle is taken once, as a whole 16-bit word.
    assign wr_fire = wr_active & ~wr_prev_reg;

    // ****************************************************************
    // Address decode
    // ****************************************************************
    logic [15:0]      window_sel_q;
    logic             hit_window_sel;
    logic             in_window;
    logic             video_sel;
    logic [EFF_W-1:0] eff_addr;
    logic             hit_ctrl;
    logic             hit_size;
    logic             hit_src;
    logic             hit_dst;
    logic             hit_vctl;

    // Top word is the selector, the rest is the sub-device window.
    assign hit_window_sel = (addr_reg == OFS_WINDOW_SEL);
    assign in_window      = (addr_reg <= OFS_WINDOW_LAST);
    assign subdev_sel     = window_sel_q[SEL_MSB:SEL_LSB];
    assign window_offset  = window_sel_q[WOFS_MSB:WOFS_LSB];
    assign video_sel      = (subdev_sel == SEL_VIDEO);

    // Window offset moves the view in 16-byte steps.
    assign eff_addr = {window_offset, WIN_STEP_ZEROS}
                    + {{(EFF_W-ADDR_W){1'b0}}, addr_reg};

    // Video registers answer only inside the window and when selected.
    assign hit_ctrl = video_sel & in_window & (eff_addr == OFS_BLIT_CTRL);
    assign hit_size = video_sel & in_window & (eff_addr == OFS_BLIT_SIZE);
    assign hit_src  = video_sel & in_window & (eff_addr == OFS_BLIT_SRC);
    assign hit_dst  = video_sel & in_window & (eff_addr == OFS_BLIT_DST);
    assign hit_vctl = video_sel & in_window & (eff_addr == OFS_VIDEO_CTRL);

    // ****************************************************************
    // Register storage
    // ****************************************************************
    logic [15:0] ctrl_q;
    logic [15:0] size_q;
    logic [15:0] src_q;
    logic [15:0] dst_q;
    logic [15:0] vctl_q;
    logic        pend_reg;
    logic [15:0] pend_data_reg;
    logic        dst_commit;
    logic [15:0] dst_wdata;
    logic        busy_reg;

    // Destination write is committed now or after the running blit.
    assign dst_commit = (wr_fire & hit_dst & ~busy_reg) | (pend_reg & ~busy_reg);
    assign dst_wdata  = pend_reg ? pend_data_reg : data_reg;

    masked_reg16 #(.WMASK(MASK_WINDOW_SEL), .RSTV(RST_ZERO)) u_window_sel (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & hit_window_sel),
        .wr_data  (data_reg),
        .value_reg(window_sel_q)
    );

    masked_reg16 #(.WMASK(MASK_FULL), .RSTV(RST_ZERO)) u_blit_ctrl (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & hit_ctrl),
        .wr_data  (data_reg),
        .value_reg(ctrl_q)
    );

    masked_reg16 #(.WMASK(MASK_FULL), .RSTV(RST_ZERO)) u_blit_size (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & hit_size),
        .wr_data  (data_reg),
        .value_reg(size_q)
    );

    masked_reg16 #(.WMASK(MASK_FULL), .RSTV(RST_ZERO)) u_blit_src (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & hit_src),
        .wr_data  (data_reg),
        .value_reg(src_q)
    );

    masked_reg16 #(.WMASK(MASK_FULL), .RSTV(RST_ZERO)) u_blit_dst (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .wr_en    (dst_commit),
        .wr_data  (dst_wdata),
        .value_reg(dst_q)
    );

    masked_reg16 #(.WMASK(MASK_VIDEO_CTRL), .RSTV(RST_ZERO)) u_video_ctrl (
        .mclk     (mclk),
        .sys_rst  (sys_rst),
        .wr_en    (wr_fire & hit_vctl),
        .wr_data  (data_reg),
        .value_reg(vctl_q)
    );

    // ****************************************************************
    // Blit start, stall and parameter clone
    // ****************************************************************

    // Holds a destination write that arrived during a running blit.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_reg      <= 1'b0;
            pend_data_reg <= RST_ZERO;
        end else if (wr_fire & hit_dst & busy_reg) begin
            pend_reg      <= 1'b1;
            pend_data_reg <= data_reg;
        end else if (dst_commit) begin
            pend_reg      <= 1'b0;
        end
    end

    // Ready drops while the stalled write waits for completion.
    assign io_ready = ~(pend_reg | (wr_fire & hit_dst & busy_reg));

    // One-cycle start pulse on each committed destination write.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            blit_start <= 1'b0;
        end else begin
            blit_start <= dst_commit;
        end
    end

    // Busy is set by a start and cleared by the engine's done.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            busy_reg <= 1'b0;
        end else if (dst_commit) begin
            busy_reg <= 1'b1;
        end else if (blit_done) begin
            busy_reg <= 1'b0;
        end
    end

    assign blit_busy = busy_reg;

    // Snapshot of every parameter so software may load the next blit.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            blit_linear     <= 1'b0;
            blit_fill       <= 1'b0;
            blit_bottom_up  <= 1'b0;
            blit_width      <= '0;
            blit_height     <= '0;
            blit_src_addr   <= '0;
            blit_dst_addr   <= '0;
            blit_fill_color <= RST_ZERO;
        end else if (dst_commit) begin
            blit_linear     <= ctrl_q[CTL_MODE];
            blit_fill       <= vctl_q[VC_FILL];
            blit_bottom_up  <= vctl_q[VC_DIR];
            blit_width      <= {ctrl_q[CTL_WHI_MSB:CTL_WHI_LSB],
                                size_q[SZ_WLO_MSB:SZ_WLO_LSB]};
            blit_height     <= size_q[SZ_H_MSB:SZ_H_LSB];
            blit_src_addr   <= {ctrl_q[CTL_SHI_MSB:CTL_SHI_LSB], src_q};
            blit_dst_addr   <= {ctrl_q[CTL_DHI_MSB:CTL_DHI_LSB], dst_wdata};
            blit_fill_color <= src_q;
        end
    end

    // ****************************************************************
    // Display controls
    // ****************************************************************
    assign hsync_en    = vctl_q[VC_HSYNC];
    assign vsync_en    = vctl_q[VC_VSYNC];
    assign raster_page = vctl_q[VC_RPG_MSB:VC_RPG_LSB];
    assign bus_page    = vctl_q[VC_BPG_MSB:VC_BPG_LSB];

    // ****************************************************************
    // Read path
    // ****************************************************************
    logic [15:0] rd_next;

    // Selects the addressed word; unmapped offsets read zero.
    always_comb begin
        rd_next = RST_ZERO;
        if (hit_window_sel) begin
            rd_next = window_sel_q;
        end else if (hit_ctrl) begin
            rd_next = ctrl_q;
        end else if (hit_size) begin
            rd_next = size_q;
        end else if (hit_src) begin
            rd_next = src_q;
        end else if (hit_dst) begin
            rd_next = dst_q;
        end else if (hit_vctl) begin
            rd_next = vctl_q;
            rd_next[VC_COMMITTED] = raster_committed;
            rd_next[VC_BUSY]      = busy_reg;
        end
    end

    // Read data come from a register and drive only during a read.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            io_data_out <= RST_ZERO;
            io_data_oe  <= 1'b0;
        end else begin
            io_data_out <= rd_next;
            io_data_oe  <= rd_active;
        end
    end

    // ****************************************************************
    // Checks
    // ****************************************************************
    stall_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
        pend_reg && busy_reg |-> !io_ready)
        else $error("Ready high while a destination write is held.");

    start_when_idle_a: assert property (@(posedge mclk) disable iff (sys_rst)
        blit_start |-> $past(busy_reg) == 1'b0)
        else $error("Blit started while another was running.");

    start_sets_busy_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dst_commit |=> busy_reg && blit_start)
        else $error("Committed destination write did not start a blit.");

    busy_readback_a: assert property (@(posedge mclk) disable iff (sys_rst)
        hit_vctl |=> io_data_out[VC_BUSY] == $past(busy_reg))
        else $error("Busy flag not reflected in video control.");

    window_reserved_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (window_sel_q & ~MASK_WINDOW_SEL) == RST_ZERO
        && (vctl_q & ~MASK_VIDEO_CTRL) == RST_ZERO)
        else $error("Reserved register bits not zero.");

    width_join_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dst_commit |=> blit_width == {$past(ctrl_q[CTL_WHI_MSB:CTL_WHI_LSB]),
                                      $past(size_q[SZ_WLO_MSB:SZ_WLO_LSB])})
        else $error("Box width not formed from both fields.");

    clone_stable_a: assert property (@(posedge mclk) disable iff (sys_rst)
        !dst_commit |=> $stable(blit_dst_addr) && $stable(blit_width))
        else $error("Cloned blit parameters changed without a start.");

    sync_enable_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_fire && hit_vctl |=> hsync_en == $past(data_reg[VC_HSYNC])
                                && vsync_en == $past(data_reg[VC_VSYNC]))
        else $error("Sync enables do not follow the written value.");

    video_only_a: assert property (@(posedge mclk) disable iff (sys_rst)
        wr_fire && !video_sel |-> !dst_commit || pend_reg)
        else $error("Destination commit while video core not selected.");

endmodule

// ### rtl/video_blit_pkg.sv
package video_blit_pkg;

    // ****************************************************************
    // Bus geometry
    // ****************************************************************
    localparam int          ADDR_W          = 5;
    localparam int          DATA_W          = 16;
    localparam int          EFF_W           = 8;

    // Byte offsets inside the 32-byte I/O space.
    localparam logic [4:0]  OFS_WINDOW_SEL  = 5'h1e;
    localparam logic [4:0]  OFS_WINDOW_LAST = 5'h1d;

    // Effective window offsets of the video core registers.
    localparam logic [7:0]  OFS_BLIT_CTRL   = 8'h00;
    localparam logic [7:0]  OFS_BLIT_SIZE   = 8'h02;
    localparam logic [7:0]  OFS_BLIT_SRC    = 8'h04;
    localparam logic [7:0]  OFS_BLIT_DST    = 8'h06;
    localparam logic [7:0]  OFS_VIDEO_CTRL  = 8'h08;

    // ****************************************************************
    // Window select fields
    // ****************************************************************
    localparam int          SEL_LSB         = 4;
    localparam int          SEL_MSB         = 7;
    localparam int          WOFS_LSB        = 0;
    localparam int          WOFS_MSB        = 3;
    localparam logic [3:0]  SEL_UART        = 4'h0;
    localparam logic [3:0]  SEL_CAN         = 4'h1;
    localparam logic [3:0]  SEL_ADC         = 4'h2;
    localparam logic [3:0]  SEL_GPIO        = 4'h3;
    localparam logic [3:0]  SEL_LED         = 4'h4;
    localparam logic [3:0]  SEL_VIDEO       = 4'h5;
    localparam logic [3:0]  WIN_STEP_ZEROS  = 4'h0;

    // ****************************************************************
    // Write masks and reset values
    // ****************************************************************
    localparam logic [15:0] MASK_FULL       = 16'hffff;
    localparam logic [15:0] MASK_WINDOW_SEL = 16'h00ff;
    localparam logic [15:0] MASK_VIDEO_CTRL = 16'h03ff;
    localparam logic [15:0] RST_ZERO        = 16'h0000;

    // ****************************************************************
    // Field positions
    // ****************************************************************
    localparam int          CTL_WHI_MSB     = 15;
    localparam int          CTL_WHI_LSB     = 13;
    localparam int          CTL_MODE        = 12;
    localparam int          CTL_DHI_MSB     = 11;
    localparam int          CTL_DHI_LSB     = 6;
    localparam int          CTL_SHI_MSB     = 5;
    localparam int          CTL_SHI_LSB     = 0;
    localparam int          SZ_WLO_MSB      = 15;
    localparam int          SZ_WLO_LSB      = 9;
    localparam int          SZ_H_MSB        = 8;
    localparam int          SZ_H_LSB        = 0;
    localparam int          VC_COMMITTED    = 11;
    localparam int          VC_BUSY         = 10;
    localparam int          VC_HSYNC        = 9;
    localparam int          VC_VSYNC        = 8;
    localparam int          VC_DIR          = 7;
    localparam int          VC_FILL         = 6;
    localparam int          VC_RPG_MSB      = 5;
    localparam int          VC_RPG_LSB      = 3;
    localparam int          VC_BPG_MSB      = 2;
    localparam int          VC_BPG_LSB      = 0;

    localparam int          WIDTH_W         = 10;
    localparam int          HEIGHT_W        = 9;
    localparam int          BADDR_W         = 22;
    localparam int          PAGE_W          = 3;

endpackage

// ### rtl/masked_reg16.sv
`timescale 1ns/10ps

// Writable register whose masked-off bits stay zero.
module masked_reg16
    import video_blit_pkg::*;
#(
    parameter logic [15:0] WMASK = MASK_FULL,
    parameter logic [15:0] RSTV  = RST_ZERO
) (
    input  wire logic        mclk,
    input  wire logic        sys_rst,
    input  wire logic        wr_en,
    input  wire logic [15:0] wr_data,
    output logic      [15:0] value_reg
);

    // Stores the written value, reserved bits forced to zero.
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            value_reg <= RSTV & WMASK;
        end else if (wr_en) begin
            value_reg <= wr_data & WMASK;
        end
    end

endmodule

// ### tb/host_io_model.sv
`timescale 1ns/10ps

// ****************************************************************
// Host processor issuing 16-bit I/O cycles on the strobe pins
// ****************************************************************
module host_io_model (
    input  wire logic        mclk,
    output logic      [4:0]  io_addr,
    output logic      [15:0] io_data_in,
    output logic             io_rd_n,
    output logic             io_wr_n,
    input  wire logic        io_ready,
    input  wire logic [15:0] io_data_out,
    input  wire logic        io_data_oe
);
    logic stalled;
    logic oe_seen;

    // Bus idles with both strobes high.
    initial begin
        io_addr    = 5'h00;
        io_data_in = 16'h0000;
        io_rd_n    = 1'b1;
        io_wr_n    = 1'b1;
        stalled    = 1'b0;
        oe_seen    = 1'b0;
    end

    // Whole 16-bit word write, held until the device lets the cycle end.
    task automatic wr(input logic [4:0] a, input logic [15:0] d);
        int n;
        @(posedge mclk);
        #1;
        io_addr    = a;
        io_data_in = d;
        io_wr_n    = 1'b0;
        repeat (5) @(posedge mclk);
        #1;
        stalled = (io_ready !== 1'b1);
        n = 0;
        while (io_ready !== 1'b1 && n < 400) begin
            @(posedge mclk);
            #1;
            n++;
        end
        @(posedge mclk);  // Ready is sampled high at this edge.
        #1;
        io_wr_n    = 1'b1;
        io_data_in = ~d;  // Released lines stop showing the old word.
        io_addr    = ~a;
        repeat (4) @(posedge mclk);
        #1;
    endtask

    // Whole 16-bit word read, sampled late in the strobe.
    task automatic rd(input logic [4:0] a, output logic [15:0] d);
        @(posedge mclk);
        #1;
        io_addr = a;
        io_rd_n = 1'b0;
        repeat (7) @(posedge mclk);
        #1;
        d       = io_data_out;
        oe_seen = io_data_oe;
        io_rd_n = 1'b1;
        io_addr = ~a;
        repeat (4) @(posedge mclk);
        #1;
    endtask
endmodule

// ### tb/tb.sv
`timescale 1ns/10ps

module tb;
    import video_blit_pkg::*;

    typedef struct packed {
        logic [4:0]  a;
        logic [15:0] w;
        logic [15:0] e;
    } row_t;

    localparam logic [15:0] CTL_V = 16'hb6c9;
    localparam logic [15:0] SZ_V  = 16'ha5a5;
    localparam logic [15:0] SRC_V = 16'h1234;
    localparam logic [15:0] VC_V  = 16'h03ab;

    logic        mclk, sys_rst, blit_done, raster_committed;
    logic [4:0]  io_addr;
    logic [15:0] io_data_in, io_data_out, blit_fill_color, rdv;
    logic        io_data_oe, io_rd_n, io_wr_n, io_ready, blit_start, blit_busy;
    logic        blit_linear, blit_fill, blit_bottom_up, hsync_en, vsync_en;
    logic [3:0]  subdev_sel, window_offset;
    logic [9:0]  blit_width;
    logic [8:0]  blit_height;
    logic [21:0] blit_src_addr, blit_dst_addr;
    logic [2:0]  raster_page, bus_page;
    int          bad_count, n_compared, cyc, eng_cnt, n;
    row_t        rows [7];

    video_blit_window_regs DUT (.mclk(mclk), .sys_rst(sys_rst), .io_addr(io_addr),
        .io_data_in(io_data_in), .io_data_out(io_data_out), .io_data_oe(io_data_oe),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_ready(io_ready),
        .subdev_sel(subdev_sel), .window_offset(window_offset), .blit_done(blit_done),
        .raster_committed(raster_committed), .blit_start(blit_start),
        .blit_busy(blit_busy), .blit_linear(blit_linear), .blit_fill(blit_fill),
        .blit_bottom_up(blit_bottom_up), .blit_width(blit_width),
        .blit_height(blit_height), .blit_src_addr(blit_src_addr),
        .blit_dst_addr(blit_dst_addr), .blit_fill_color(blit_fill_color),
        .hsync_en(hsync_en), .vsync_en(vsync_en), .raster_page(raster_page),
        .bus_page(bus_page));

    host_io_model host (.mclk(mclk), .io_addr(io_addr), .io_data_in(io_data_in),
        .io_rd_n(io_rd_n), .io_wr_n(io_wr_n), .io_ready(io_ready),
        .io_data_out(io_data_out), .io_data_oe(io_data_oe));

    // Clock at 4 ns period.
    always #2 mclk = ~mclk;

    // Engine stand-in: finishes a transfer 80 cycles after it starts.
    always @(posedge mclk) begin
        blit_done <= #1 (eng_cnt == 1);
        if (blit_start === 1'b1) begin
            eng_cnt <= 80;
        end else if (eng_cnt != 0) begin
            eng_cnt <= eng_cnt - 1;
        end
    end

    // Watchdog against a hung bus cycle.
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            close_out();
        end
    end

    // Compares one observed value with its expectation.
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic close_out();
        $display("Compared %0d values, %0d mismatches", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        mclk = 1'b0;
        sys_rst = 1'b1;
        blit_done = 1'b0;
        raster_committed = 1'b1;
        bad_count = 0;
        n_compared = 0;
        cyc = 0;
        eng_cnt = 0;
        rows[0] = '{5'h1e, 16'hab50, 16'h0050};
        rows[1] = '{5'h00, CTL_V, CTL_V};
        rows[2] = '{5'h02, SZ_V, SZ_V};
        rows[3] = '{5'h04, SRC_V, SRC_V};
        rows[4] = '{5'h08, 16'hffab, 16'h0bab};
        rows[5] = '{5'h0a, 16'hffff, 16'h0000};
        rows[6] = '{5'h1c, 16'hffff, 16'h0000};
        repeat (2) @(posedge mclk);
        #1 sys_rst = 1'b0;
        for (int i = 0; i < 7; i++) begin
            host.wr(rows[i].a, rows[i].w);
            host.rd(rows[i].a, rdv);
            chk(rdv, rows[i].e);
            $display("Row %0d done", i);
        end
        chk({subdev_sel, window_offset, hsync_en, vsync_en}, {8'h50, VC_V[9:8]});
        chk({raster_page, bus_page}, VC_V[5:0]);
        // Destination write starts a transfer and clones the parameters.
        host.wr(5'h06, 16'h0f0f);
        chk(blit_busy, 1'b1);
        chk({blit_width, blit_height}, {CTL_V[15:13], SZ_V[15:9], SZ_V[8:0]});
        chk({blit_linear, blit_fill, blit_bottom_up}, {CTL_V[12], VC_V[6], VC_V[7]});
        chk(blit_src_addr, {CTL_V[5:0], SRC_V});
        chk(blit_dst_addr, {CTL_V[11:6], 16'h0f0f});
        chk(blit_fill_color, SRC_V);
        host.wr(5'h00, 16'h0000);
        chk(blit_width, {CTL_V[15:13], SZ_V[15:9]});
        host.rd(5'h08, rdv);
        chk(rdv, 16'h0fab);
        chk(host.oe_seen, 1'b1);
        host.wr(5'h06, 16'h1111);
        chk(host.stalled, 1'b1);
        chk(blit_width, {3'b000, SZ_V[15:9]});
        n = 0;
        while (blit_busy !== 1'b0 && n < 300) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk(blit_busy, 1'b0);
        chk(blit_dst_addr, {6'h00, 16'h1111});
        raster_committed = 1'b0;
        host.rd(5'h08, rdv);
        chk(rdv, 16'h03ab);
        $display("Transfer and stall test done");
        // Writes land nowhere while another sub-device is chosen; another window page reads no register.
        host.wr(5'h1e, 16'h0040);
        host.rd(5'h00, rdv);
        chk(rdv, 16'h0000);
        host.wr(5'h00, 16'hffff);
        host.wr(5'h1e, 16'h0051);
        host.rd(5'h00, rdv);
        chk(rdv, 16'h0000);
        host.wr(5'h1e, 16'h0050);
        host.rd(5'h00, rdv);
        chk(rdv, 16'h0000);
        $display("Window selection test done");
        // Reset in mid-run clears the window selection.
        @(posedge mclk);
        #1 sys_rst = 1'b1;
        repeat (2) @(posedge mclk);
        #1 sys_rst = 1'b0;
        chk({io_ready, blit_busy, subdev_sel}, 6'h20);
        host.rd(5'h1e, rdv);
        chk(rdv, 16'h0000);
        $display("Reset test done");
        close_out();
    end
endmodule
